/* rtl/ciel_pkg.sv */
// Functional notes
// R01: a status bit sets only if its enable was already set before the event.
// R02: writing zero to an enable bit clears its status bit at once.
// R03: interrupt output is high while any status bit is set.
// R04: enable bit 29 lets frame timer expiry raise an event; resets to zero.
// R05: enable bit 28 lets each frame trigger raise an event; resets to zero.
// R06: enable bit 24 raises group one done on busy falling, manual mode only.
// R07: enable bits 25 to 27 do the same for groups two to four.
// R08: bits 31 and 30 of the enable register are reserved.
// R09: frame timer expires after programmed count plus one conversion clock ticks.
// R10: reserved enable bits read zero and ignore writes.
package ciel_pkg;
    localparam logic [11:0] CIEL_ENABLE_OFFSET   = 12'h036c;
    localparam int          CIEL_FRAME_EXP_BIT   = 29;
    localparam int          CIEL_FRAME_TRIG_BIT  = 28;
    localparam int          CIEL_GROUP1_BIT      = 24;
    localparam int          CIEL_NUM_GROUPS      = 4;
    localparam int          CIEL_NUM_SOURCES     = 6;
    localparam logic [31:0] CIEL_ENABLE_RESET    = 32'h0000_0000;
    localparam logic [31:0] CIEL_ENABLE_WMASK    = 32'h3f00_0000;
    localparam int          CIEL_TIMER_WIDTH     = 28;
    localparam logic [27:0] CIEL_TIMER_RESET     = 28'hfff_ffff;
endpackage

/* rtl/ciel_irq_enable.sv */
`timescale 1ns/1ps
`default_nettype none
module ciel_irq_enable
    import ciel_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic [11:0] i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [31:0] i_wdata,
    output logic      [31:0] o_rdata,
    input  wire logic        i_manual_mode,
    input  wire logic        i_frame_trigger,
    input  wire logic        i_timer_enable,
    input  wire logic        i_conv_clk_tick,
    input  wire logic [27:0] i_frame_timer_count,
    input  wire logic [3:0]  i_group_converting_flag,
    output logic      [5:0]  o_irq_status,
    output logic             o_irq
);
    // ******************************
    // register access
    // ******************************
    logic [31:0] enable_q;
    logic [31:0] enable_d;
    wire         sel_enable = (i_addr == CIEL_ENABLE_OFFSET);
    wire         wr_enable  = i_wr && sel_enable;

    assign enable_d = wr_enable ? (i_wdata & CIEL_ENABLE_WMASK) : enable_q; // R10 R08

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            enable_q <= CIEL_ENABLE_RESET;
        else
            enable_q <= enable_d;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            o_rdata <= 32'h0000_0000;
        else if (i_rd && sel_enable)
            o_rdata <= enable_q;
        else
            o_rdata <= 32'h0000_0000;
    end

    // ******************************
    // frame timer
    // ******************************
    logic [27:0] timer_q;
    logic        timer_run_q;
    wire         timer_done = timer_run_q && i_conv_clk_tick && (timer_q == i_frame_timer_count);

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            timer_q     <= 28'h000_0000;
            timer_run_q <= 1'b0;
        end
        else if (i_frame_trigger && i_timer_enable)
        begin
            timer_q     <= 28'h000_0000;
            timer_run_q <= 1'b1;
        end
        else if (timer_done)
            timer_run_q <= 1'b0; // R09
        else if (timer_run_q && i_conv_clk_tick)
            timer_q <= timer_q + 28'h000_0001;
    end

    // ******************************
    // event detection
    // ******************************
    logic [3:0] busy_q;
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            busy_q <= 4'h0;
        else
            busy_q <= i_group_converting_flag;
    end

    // busy falling means result data is ready
    wire [3:0] group_done = busy_q & ~i_group_converting_flag & {4{i_manual_mode}}; // R06 R07
    wire [5:0] events     = {timer_done, i_frame_trigger, group_done}; // R04 R05
    // enable taken from the register, not the incoming write
    wire [5:0] en_now     = enable_q[CIEL_FRAME_EXP_BIT:CIEL_GROUP1_BIT];
    wire [5:0] en_next    = enable_d[CIEL_FRAME_EXP_BIT:CIEL_GROUP1_BIT];
    wire [5:0] status_d   = (o_irq_status | (events & en_now)) & en_next; // R01 R02

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_irq_status <= 6'h00;
            o_irq        <= 1'b0;
        end
        else
        begin
            o_irq_status <= status_d;
            o_irq        <= |status_d; // R03
        end
    end

    // ******************************
    // helper logic for checks
    // ******************************
    // own tick count since restart, so the expiry check never leans on timer_q
    logic [28:0] ticks_seen_q;
    // one bit wider than the count, so count plus one never wraps
    wire  [28:0] count_ext = {1'b0, i_frame_timer_count};

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            ticks_seen_q <= 29'h0000_0000;
        else if (i_frame_trigger && i_timer_enable)
            ticks_seen_q <= 29'h0000_0000;
        else if (timer_run_q && i_conv_clk_tick)
            ticks_seen_q <= ticks_seen_q + 29'h0000_0001;
    end

    // ******************************
    // checks
    // ******************************
    AST_SET_NEEDS_EN: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R01
        $rose(o_irq_status[0]) |-> $past(enable_q[CIEL_GROUP1_BIT]))
        else $error("status set without prior enable");
    AST_CLEAR_ON_DISABLE: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R02
        (wr_enable && !i_wdata[CIEL_FRAME_TRIG_BIT]) |=> !o_irq_status[4])
        else $error("status not cleared on disable");
    AST_IRQ_FOLLOWS: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R03
        o_irq == (|o_irq_status))
        else $error("irq mismatch");
    AST_TIMER_EVT: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R04
        (timer_done && enable_q[CIEL_FRAME_EXP_BIT] && !wr_enable) |=> o_irq_status[5])
        else $error("timer event lost");
    AST_TRIG_EVT: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R05
        (i_frame_trigger && enable_q[CIEL_FRAME_TRIG_BIT] && !wr_enable) |=> o_irq_status[4])
        else $error("trigger event lost");
    AST_GROUP_EVT: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R06
        (busy_q[0] && !i_group_converting_flag[0] && i_manual_mode && enable_q[CIEL_GROUP1_BIT] && !wr_enable)
        |=> o_irq_status[0])
        else $error("group done lost");
    AST_GROUP4_EVT: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R07
        (busy_q[3] && !i_group_converting_flag[3] && i_manual_mode && enable_q[27] && !wr_enable)
        |=> o_irq_status[3])
        else $error("group four done lost");
    AST_RESERVED_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R08 R10
        enable_q[31:30] == 2'b00 && enable_q[23:0] == 24'h00_0000)
        else $error("reserved bits set");
    AST_TIMER_COUNT: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R09
        timer_done |-> timer_q == i_frame_timer_count)
        else $error("timer expired early");

    // ******************************
    // more event and read checks
    // ******************************
    AST_GROUP2_EVT: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R07
        (busy_q[1] && !i_group_converting_flag[1] && i_manual_mode && enable_q[25] && !wr_enable)
        |=> o_irq_status[1])
        else $error("group two done lost");

    AST_GROUP3_EVT: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R07
        (busy_q[2] && !i_group_converting_flag[2] && i_manual_mode && enable_q[26] && !wr_enable)
        |=> o_irq_status[2])
        else $error("group three done lost");

    // outside manual mode busy edges must not raise anything
    AST_GROUP_MANUAL_ONLY: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R06
        (!i_manual_mode && !timer_done && !i_frame_trigger) |=> (o_irq_status & ~$past(o_irq_status)) == 6'h00)
        else $error("group event outside manual mode");

    AST_TRIG_NEEDS_EN: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R01
        $rose(o_irq_status[4]) |-> $past(enable_q[CIEL_FRAME_TRIG_BIT]))
        else $error("trigger status set without prior enable");

    AST_TIMER_NEEDS_EN: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R01
        $rose(o_irq_status[5]) |-> $past(enable_q[CIEL_FRAME_EXP_BIT]))
        else $error("timer status set without prior enable");

    // a disabled source can never hold status, whatever the write order
    AST_STATUS_MASKED: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R02
        (o_irq_status & ~enable_q[CIEL_FRAME_EXP_BIT:CIEL_GROUP1_BIT]) == 6'h00)
        else $error("status held for disabled source");

    AST_READ_BACK: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R10
        (i_rd && sel_enable) |=> o_rdata == $past(enable_q))
        else $error("read data wrong");

    // idle zero keeps a shared read path clean
    AST_READ_IDLE: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R10
        !(i_rd && sel_enable) |=> o_rdata == 32'h0000_0000)
        else $error("read data not zero when idle");

    // ******************************
    // timer checks
    // ******************************
    AST_TIMER_TICKS: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R09
        timer_done |-> ticks_seen_q == count_ext)
        else $error("timer expired on wrong tick");

    // count must not drop below the ticks already seen during a run, or this fires
    AST_TIMER_NOT_LATE: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // R09
        timer_run_q |-> ticks_seen_q <= count_ext)
        else $error("timer overran its count");

    // ******************************
    // coverage
    // ******************************
    COV_TRIG: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_irq_status[4]));
    COV_TIMER: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_irq_status[5]));
    COV_GROUP: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_irq_status[2]));
    COV_IRQ: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_irq));
    COV_CLEAR: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $fell(o_irq));
endmodule
`default_nettype wire

/* verification/ciel_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ciel_host_model (
    input  wire logic        i_mclk,
    input  wire logic [31:0] i_rdata,
    output logic      [11:0] o_addr,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [31:0] o_wdata
);
    initial {o_addr, o_wr, o_rd, o_wdata} = '0;
    task automatic access(input logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] r);
        @(posedge i_mclk);
        {o_addr, o_wdata, o_wr, o_rd} <= {a, d, w, !w};
        @(posedge i_mclk);
        {o_wdata, o_wr, o_rd} <= {~d, 2'b00}; // inverted so stale data never passes
        #1 r = i_rdata;
    endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import ciel_pkg::*;;
    localparam int CNT = 2;
    logic        mclk = 0, rst_n = 0, man = 0, trig = 0, ten = 0, tk = 0, wr, rd, irq, run;
    logic [3:0]  flag = '0, pf;
    logic [5:0]  st, ev, stat;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, en, r, tc;
    int          seed = 74118, miscompares = 0, comparisons = 0;
    always #12.5 mclk = ~mclk;
    ciel_host_model host (.i_mclk(mclk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
    ciel_irq_enable dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
        .o_rdata(rdata), .i_manual_mode(man), .i_frame_trigger(trig), .i_timer_enable(ten), .i_conv_clk_tick(tk),
        .i_frame_timer_count(28'(CNT)), .i_group_converting_flag(flag), .o_irq_status(stat), .o_irq(irq));
    always @(posedge mclk)
    begin
        ev = {1'b0, trig, pf & ~flag & {4{man}}};
        if (tk && run && ++tc == CNT + 1) {ev[5], run} = 2'b10;
        if (trig && ten) {run, tc} = {1'b1, 32'h0000_0000};
        st = st | ev & en[29:24];
        if (wr && addr == CIEL_ENABLE_OFFSET) en = wdata & CIEL_ENABLE_WMASK;
        {st, pf} = {st & en[29:24], flag};
        if (!rst_n) {en, st, run, tc} = '0;
    end
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        miscompares += int'(got !== exp);
        if (got !== exp) $display("wrong value %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic finish_test(input int extra);
        miscompares += extra;
        $display("checks %0d errors %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        host.access(1'b0, CIEL_ENABLE_OFFSET, '0, r);
        chk(r, 32'h0000_0000);
        host.access(1'b1, 12'h0370, 32'hffff_ffff, r);
        host.access(1'b0, 12'h0370, '0, r);
        chk(r, 32'h0000_0000);
        repeat (40)
        begin
            host.access(1'b1, CIEL_ENABLE_OFFSET, $random(seed), r);
            host.access(1'b0, CIEL_ENABLE_OFFSET, '0, r);
            chk(r, en);
            chk(32'(stat), 32'(st));
            @(posedge mclk) {trig, ten, man, flag} <= {2'b11, 5'($random(seed))};
            repeat (CNT + 1) @(posedge mclk) {trig, tk, flag} <= {2'b01, 4'($random(seed))};
            @(posedge mclk) tk <= 1'b0;
            #101 chk(32'(stat), 32'(st));
            chk(32'(irq), 32'(st != 0));
        end
        finish_test(0);
    end
    initial #100000 finish_test(1);
endmodule
`default_nettype wire
